//--- src/sms_spi_defs.vh
// Functional notes
// RL1 - Interrupt request needs both SPI interrupt enable and serial-port interrupt enable.
// RL2 - Channel enable bit activates the serial pins; cleared disables the channel.
// RL3 - Bit order one shifts LSB first, zero shifts MSB first.
// RL4 - Master select one generates SCK; zero makes a slave clocked by SCK.
// RL5 - Master idles SCK at the clock polarity level.
// RL6 - Phase and polarity pick one of four sample and shift relationships.
// RL7 - Master SCK is oscillator over 4/16/64/128, or 2/8/32/64 doubled.
// RL8 - Slave ignores rate bits and follows incoming SCK.
// RL9 - Each finished byte sets transfer-done flag and may raise interrupt.
// RL10 - Done flag clears only after status read then data access.
// RL11 - Normal mode write during transfer sets collision flag and is dropped.
// RL12 - Normal mode collision flag clears with the done clearing sequence.
// RL13 - Enhanced mode collision flag means buffer full; writes overwrite it.
// RL14 - Enhanced buffer-full clears when the buffer moves into shift register.
// RL15 - Slave output disable bit keeps MISO undriven.
// RL16 - Enhanced bit selects double-buffered transmit writes.
// RL17 - Transmit buffer shares the data register address.
// RL18 - Data register clears on cold reset, kept on warm reset.
// RL19 - Slave not reloaded echoes the byte last received.
// RL20 - Software configures format first and enables master before slaves.
// RL21 - Load window high during bits 0-3, low during bits 4-7.
// RL22 - Serial interrupt ORs UART flags and enabled done flag; no auto clear.
// RL23 - Clock double bit bypasses the halving, selecting faster divisors.
`ifndef SMS_SPI_DEFS_VH
`define SMS_SPI_DEFS_VH
// Register indexes; byte address is four times the index
`define SMS_IDX_DATA 10'h086
`define SMS_IDX_STAT 10'h0aa
`define SMS_IDX_CTRL 10'h0d5
`define SMS_IDX_CFG 10'h08f
// Control register fields
`define SMS_CTRL_IRQEN 7
`define SMS_CTRL_EN 6
`define SMS_CTRL_ORDER 5
`define SMS_CTRL_MASTER_SELECT 4
`define SMS_CTRL_CLOCK_POLARITY 3
`define SMS_CTRL_CLOCK_PHASE 2
`define SMS_CTRL_RATE_HI 1
`define SMS_CTRL_RATE_LO 0
`define SMS_CTRL_RST 8'h04
// Status register fields
`define SMS_STAT_DONE 7
`define SMS_STAT_COL 6
`define SMS_STAT_LDW 5
`define SMS_STAT_SLAVE_OUT_DISABLE 1
`define SMS_STAT_ENH 0
// Configuration register fields
`define SMS_CFG_X2 0
`define SMS_CFG_ES 1
// Half SCK period in aclk cycles, normal and doubled
`define SMS_HALF_R0 7'd2
`define SMS_HALF_R1 7'd8
`define SMS_HALF_R2 7'd32
`define SMS_HALF_R3 7'd64
`define SMS_HALF_X0 7'd1
`define SMS_HALF_X1 7'd4
`define SMS_HALF_X2 7'd16
`define SMS_HALF_X3 7'd32
`define SMS_LAST_EDGE 4'hf
`define SMS_RESP_OKAY 2'b00
`define SMS_RESP_SLVERR 2'b10
`endif

//--- src/sms_spi_port.v
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "sms_spi_defs.vh"
module sms_spi_port #(
    parameter ADDR_W = 12
) (
    // Clock and resets
    input wire aclk,
    input wire aresetn,
    input wire cold_resetn,
    // AXI4-Lite write
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // Serial pins
    input wire ss_n_i,
    input wire sck_i,
    output wire sck_o,
    output wire sck_oe,
    input wire mosi_i,
    output wire mosi_o,
    output wire mosi_oe,
    input wire miso_i,
    output wire miso_o,
    output wire miso_oe,
    // Shared serial interrupt
    input wire uart_rx_flag,
    input wire uart_tx_flag,
    output wire serial_irq
);
    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    reg [7:0] ctrl_q, data_q, buf_q, sr_q, sr_d;
    reg [7:0] rd_byte;
    reg done_q, col_q, full_q, armed_q, slave_out_disable_q, enh_q, x2_q, es_q;
    reg ldw_q, run_q, sck_q, sck_p_q, rbit_q, out_q;
    reg sck_oe_q, mosi_oe_q, miso_oe_q, irq_q;
    reg [3:0] e_q;
    reg [6:0] cnt_q, half;
    reg [3:0] s1_q, s2_q;
    reg awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    reg aw_have_q, w_have_q;
    reg [1:0] bresp_q, rresp_q;
    reg [31:0] rdata_q;
    reg [ADDR_W-1:0] awaddr_q;
    reg [7:0] wdata_q;
    reg wstrb0_q;

    wire en = ctrl_q[`SMS_CTRL_EN];
    wire master_select = ctrl_q[`SMS_CTRL_MASTER_SELECT];
    wire clock_polarity = ctrl_q[`SMS_CTRL_CLOCK_POLARITY];
    wire clock_phase = ctrl_q[`SMS_CTRL_CLOCK_PHASE];
    wire lsb1 = ctrl_q[`SMS_CTRL_ORDER];
    wire [1:0] rate = {ctrl_q[`SMS_CTRL_RATE_HI], ctrl_q[`SMS_CTRL_RATE_LO]};

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Order: 3 ss_n, 2 sck, 1 mosi, 0 miso
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 4'hc;
            s2_q <= 4'hc;
        end else begin
            s1_q <= {ss_n_i, sck_i, mosi_i, miso_i};
            s2_q <= s1_q;
        end
    end
    wire ss_s = s2_q[3];
    wire sck_s = s2_q[2];
    wire in_bit = master_select ? s2_q[0] : s2_q[1];

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire [9:0] widx = awaddr_q[ADDR_W-1:2];
    wire [9:0] ridx = s_axi_araddr[ADDR_W-1:2];
    wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
    wire wr_ok = (widx == `SMS_IDX_DATA) | (widx == `SMS_IDX_STAT) |
                 (widx == `SMS_IDX_CTRL) | (widx == `SMS_IDX_CFG);
    wire wr_en = wr_go & wstrb0_q;
    wire ar_hs = s_axi_arvalid & arready_q;
    wire dwr = wr_en & (widx == `SMS_IDX_DATA);
    wire drd = ar_hs & (ridx == `SMS_IDX_DATA);
    wire srd = ar_hs & (ridx == `SMS_IDX_STAT);
    wire rd_ok = (ridx == `SMS_IDX_DATA) | (ridx == `SMS_IDX_STAT) |
                 (ridx == `SMS_IDX_CTRL) | (ridx == `SMS_IDX_CFG);

    // ----------------------------------------
    // Transfer control
    // ----------------------------------------
    always @* begin
        case ({x2_q, rate})
            3'b000: half = `SMS_HALF_R0; // RL7
            3'b001: half = `SMS_HALF_R1;
            3'b010: half = `SMS_HALF_R2;
            3'b011: half = `SMS_HALF_R3;
            3'b100: half = `SMS_HALF_X0; // RL23
            3'b101: half = `SMS_HALF_X1;
            3'b110: half = `SMS_HALF_X2;
            default: half = `SMS_HALF_X3;
        endcase
    end
    wire tick = run_q & (cnt_q == half - 7'd1);
    // Slave edges come only from the pin; rate bits play no part
    wire ev_s = en & ~master_select & ~ss_s & (sck_s != sck_p_q); // RL8 RL4
    wire ev = (en & master_select & tick) | ev_s;
    wire busy = master_select ? run_q : (e_q != 4'h0);
    wire last = ev & (e_q == `SMS_LAST_EDGE);
    wire samp = ev & (e_q[0] == clock_phase); // RL6
    wire shft = ev & (e_q[0] != clock_phase) & ~(clock_phase & (e_q == 4'h0)); // RL6
    wire sin = samp ? in_bit : rbit_q;
    wire ld = dwr & ~enh_q & ~busy; // RL16
    wire mv = en & enh_q & full_q & ~busy & ~ld; // RL14
    wire start = en & master_select & (ld | mv);
    wire clr = armed_q & (dwr | drd); // RL10

    always @* begin
        sr_d = sr_q;
        if (ld)
            sr_d = wdata_q;
        else if (mv)
            sr_d = buf_q;
        else if (shft | (last & clock_phase)) begin
            if (lsb1)
                sr_d = {sin, sr_q[7:1]}; // RL3
            else
                sr_d = {sr_q[6:0], sin}; // RL3
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            sr_q <= 8'h00;
            run_q <= 1'b0;
            e_q <= 4'h0;
            cnt_q <= 7'h00;
            sck_q <= 1'b0;
            sck_p_q <= 1'b0;
            rbit_q <= 1'b0;
            out_q <= 1'b0;
            ldw_q <= 1'b1;
            sck_oe_q <= 1'b0;
            mosi_oe_q <= 1'b0;
            miso_oe_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            sr_q <= sr_d; // RL19
            sck_p_q <= sck_s;
            out_q <= lsb1 ? sr_d[0] : sr_d[7];
            if (samp)
                rbit_q <= in_bit;
            if (!en || (!master_select && ss_s)) begin
                e_q <= 4'h0;
                run_q <= master_select & run_q & en;
            end else if (ev)
                e_q <= e_q + 4'h1;
            if (start) begin
                run_q <= 1'b1;
                cnt_q <= 7'h00;
            end else if (tick)
                cnt_q <= 7'h00;
            else if (run_q)
                cnt_q <= cnt_q + 7'h01;
            if (last & master_select)
                run_q <= 1'b0;
            if (!(en & master_select))
                sck_q <= clock_polarity; // RL5
            else if (tick)
                sck_q <= ~sck_q;
            else if (!run_q)
                sck_q <= clock_polarity; // RL5
            ldw_q <= ~busy | ~e_q[3]; // RL21
            sck_oe_q <= en & master_select; // RL2
            mosi_oe_q <= en & master_select; // RL2
            miso_oe_q <= en & ~master_select & ~ss_s & ~slave_out_disable_q; // RL15
            irq_q <= es_q & ((done_q & ctrl_q[`SMS_CTRL_IRQEN]) |
                    uart_rx_flag | uart_tx_flag); // RL1 RL22
        end
    end

    // ----------------------------------------
    // Flags and buffer
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            done_q <= 1'b0;
            col_q <= 1'b0;
            full_q <= 1'b0;
            armed_q <= 1'b0;
            buf_q <= 8'h00;
        end else begin
            done_q <= last | (done_q & ~clr); // RL9 RL10
            if (dwr & ~enh_q & busy)
                col_q <= 1'b1; // RL11
            else if (clr)
                col_q <= 1'b0; // RL12
            if (dwr & enh_q) begin
                buf_q <= wdata_q; // RL13 RL17
                full_q <= 1'b1; // RL13
            end else if (mv | ~enh_q)
                full_q <= 1'b0; // RL14
            if (srd)
                armed_q <= 1'b1;
            else if (clr)
                armed_q <= 1'b0;
        end
    end

    // Cold reset only; a warm reset leaves the received byte in place
    always @(posedge aclk) begin
        if (!cold_resetn)
            data_q <= 8'h00; // RL18
        else if (last)
            data_q <= sr_d;
        else if (ld)
            data_q <= wdata_q;
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `SMS_CTRL_RST;
            slave_out_disable_q <= 1'b0;
            enh_q <= 1'b0;
            x2_q <= 1'b0;
            es_q <= 1'b0;
        end else if (wr_en) begin
            if (widx == `SMS_IDX_CTRL)
                ctrl_q <= wdata_q;
            if (widx == `SMS_IDX_STAT) begin
                slave_out_disable_q <= wdata_q[`SMS_STAT_SLAVE_OUT_DISABLE]; // RL15
                enh_q <= wdata_q[`SMS_STAT_ENH]; // RL16
            end
            if (widx == `SMS_IDX_CFG) begin
                x2_q <= wdata_q[`SMS_CFG_X2]; // RL23
                es_q <= wdata_q[`SMS_CFG_ES];
            end
        end
    end

    always @* begin
        rd_byte = 8'h00;
        case (ridx)
            `SMS_IDX_DATA: rd_byte = data_q;
            `SMS_IDX_CTRL: rd_byte = ctrl_q;
            `SMS_IDX_CFG: rd_byte = {6'h00, es_q, x2_q};
            `SMS_IDX_STAT: begin
                rd_byte[`SMS_STAT_DONE] = done_q;
                rd_byte[`SMS_STAT_COL] = enh_q ? full_q : col_q; // RL13
                rd_byte[`SMS_STAT_LDW] = ldw_q;
                rd_byte[`SMS_STAT_SLAVE_OUT_DISABLE] = slave_out_disable_q;
                rd_byte[`SMS_STAT_ENH] = enh_q;
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------
    // AXI4-Lite handshakes
    // ----------------------------------------
    // One write and one read in flight; readies drop until the answer goes
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bresp_q <= `SMS_RESP_OKAY;
            rresp_q <= `SMS_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            awaddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid & awready_q) begin
                awaddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid & wready_q) begin
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `SMS_RESP_OKAY : `SMS_RESP_SLVERR;
            end
            if (bvalid_q & s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
            if (ar_hs) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rd_byte};
                rresp_q <= rd_ok ? `SMS_RESP_OKAY : `SMS_RESP_SLVERR;
            end
            if (rvalid_q & s_axi_rready) begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign sck_o = sck_q;
    assign sck_oe = sck_oe_q;
    assign mosi_o = out_q;
    assign mosi_oe = mosi_oe_q;
    assign miso_o = out_q;
    assign miso_oe = miso_oe_q;
    assign serial_irq = irq_q;
endmodule
`default_nettype wire

//--- tb/sms_spi_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sms_spi_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial side
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic serial_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------
    // Handshakes
    // ----------------
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response missing");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above the byte");
    a_write_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_master_pins: assert property (sck_oe == mosi_oe)
        else $error("clock and data enables disagree");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn
        |=> !sck_oe && !mosi_oe && !s_axi_bvalid && !s_axi_rvalid && !serial_irq)
        else $error("outputs active after reset");
endmodule
bind sms_spi_port sms_spi_assertions sms_spi_assertions_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .sck_oe, .mosi_oe, .serial_irq);
`default_nettype wire

//--- tb/sms_spi_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module sms_spi_slave_model #(
    parameter logic [7:0] INIT = 8'h3c
) (
    // Serial pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    output logic miso
);
    logic [7:0] sr_q = INIT;
    logic smp_q = 1'b0;
    // Mode 0 only: sample on rising, shift on falling
    always @(posedge sck) begin
        if (!sel_n) begin
            smp_q <= mosi;
        end
    end
    always @(negedge sck) begin
        if (!sel_n) begin
            sr_q <= {sr_q[6:0], smp_q};
        end
    end
    // Deselected, the line shows the opposite of its last bit
    assign miso = sel_n ? ~sr_q[7] : sr_q[7];
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "sms_spi_defs.vh"
module testbench;
    localparam logic [11:0] A_D = {`SMS_IDX_DATA, 2'b00};
    localparam logic [11:0] A_S = {`SMS_IDX_STAT, 2'b00};
    localparam logic [11:0] A_C = {`SMS_IDX_CTRL, 2'b00};
    localparam logic [11:0] A_F = {`SMS_IDX_CFG, 2'b00};
    logic aclk = 1'b0, aresetn = 1'b0, cold_resetn = 1'b0, ss_n_i = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, part_miso;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic serial_irq, ord;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] p = 8'h3c, tx, c;
    int fails = 0, samples_checked = 0, i;
    // Pulled-down lines where nobody drives
    wire logic sck_i = sck_oe ? sck_o : 1'b0;
    wire logic mosi_i = mosi_oe ? mosi_o : 1'b0;
    wire logic miso_i = miso_oe ? miso_o : part_miso;
    always #5 aclk = ~aclk;
    sms_spi_port sms_spi_port_i (.aclk, .aresetn, .cold_resetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ss_n_i, .sck_i, .sck_o, .sck_oe, .mosi_i, .mosi_o,
        .mosi_oe, .miso_i, .miso_o, .miso_oe, .uart_rx_flag(1'b0),
        .uart_tx_flag(1'b0), .serial_irq);
    sms_spi_slave_model sms_spi_slave_model_i (.sck(sck_i), .mosi(mosi_i),
        .sel_n(ss_n_i), .miso(part_miso));
    // ----------------
    // Bus tasks
    // ----------------
    task automatic stop_test;
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        int n;
        logic dn;
        dn = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64 && !dn; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                r = s_axi_bresp;
                dn = 1'b1;
            end
        end
        if (!dn) begin
            fails++;
            stop_test();
        end
        @(posedge aclk);
        chk_r(r, `SMS_RESP_OKAY);
    endtask
    task automatic rd(input logic [11:0] a);
        int n;
        logic dn;
        dn = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64 && !dn; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                r = s_axi_rresp;
                dn = 1'b1;
            end
        end
        if (!dn) begin
            fails++;
            stop_test();
        end
        @(posedge aclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] m,
                       input logic [7:0] e);
        rd(a);
        chk_v(d & {24'h0, m}, {24'h0, e});
    endtask
    task automatic wst(input logic [7:0] m, input logic [7:0] v);
        int n;
        for (n = 0; n < 1000; n++) begin
            rd(A_S);
            if ((d[7:0] & m) === v) return;
        end
        fails++;
        stop_test();
    endtask
    task automatic mhalf(input int e);
        int n, h;
        logic s;
        s = sck_o;
        for (n = 0; n < 300 && sck_o === s; n++) @(posedge aclk);
        s = sck_o;
        h = 0;
        for (n = 0; n < 300 && sck_o === s; n++) begin
            @(posedge aclk);
            h++;
        end
        chk_v(h, e);
    endtask
    function automatic logic [7:0] rev(input logic [7:0] x);
        for (int k = 0; k < 8; k++) rev[k] = x[7-k];
    endfunction
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        cold_resetn <= 1'b1;
        @(posedge aclk);
        rdc(A_D, 8'hff, 8'h00);
        rdc(A_C, 8'hff, `SMS_CTRL_RST);
        rdc(A_S, 8'hc3, 8'h00);
        rd(12'h004);
        chk_r(r, `SMS_RESP_SLVERR);
        wr(A_D, 8'h5a);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(A_D, 8'hff, 8'h5a);
        ss_n_i <= 1'b0;
        // Rate, clock double and bit order, one transfer each
        for (i = 0; i < 4; i++) begin
            ord = i[0] ^ i[1];
            c = {2'b11, ord, 3'b100, i[0], 1'b1};
            tx = 8'ha5 + i[7:0];
            wr(A_F, {6'h0, 1'b1, i[1]});
            wr(A_C, c & 8'hbf);
            wr(A_C, c);
            wr(A_D, tx);
            mhalf(i[1] ? (i[0] ? `SMS_HALF_X3 : `SMS_HALF_X1)
                : (i[0] ? `SMS_HALF_R3 : `SMS_HALF_R1));
            wr(A_D, 8'h00);
            wst(8'h80, 8'h80);
            chk_v({31'h0, serial_irq}, 32'h1);
            rdc(A_S, 8'hc0, 8'hc0);
            rdc(A_D, 8'hff, ord ? rev(p) : p);
            p = ord ? rev(tx) : tx;
            rdc(A_S, 8'hc0, 8'h00);
            chk_v({31'h0, serial_irq}, 32'h0);
        end
        wr(A_F, 8'h02);
        wr(A_C, 8'h53);
        wr(A_S, 8'h01);
        wr(A_D, 8'h81);
        wr(A_D, 8'h42);
        rdc(A_S, 8'h61, 8'h61);
        rd(A_D);
        rdc(A_S, 8'h40, 8'h40);
        wst(8'h20, 8'h00);
        wst(8'h40, 8'h00);
        rdc(A_D, 8'hff, p);
        wst(8'h80, 8'h80);
        rdc(A_D, 8'hff, 8'h81);
        wr(A_S, 8'h00);
        wr(A_C, 8'h40);
        chk_v({31'h0, miso_oe}, 32'h1);
        wr(A_S, 8'h02);
        chk_v({31'h0, miso_oe}, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
